// [adc_ctl_pkg.sv]
// Shared constants and types for the serial converter control block
package adc_ctl_pkg;

  localparam int          FRAME_EDGES      = 16;  // Rising edges per frame
  localparam int          MSB_EDGE         = 4;   // First data bit edge
  localparam int          PD_WIN_LO        = 3;   // Power-down window start
  localparam int          PD_WIN_HI        = 14;  // Power-down window end
  localparam int          TRACK_EDGE       = 14;  // Track resumes here
  localparam int          WAKE_EDGES       = 14;  // Edges to leave power-down
  localparam int          DATA_BITS        = 10;
  localparam int          SUB_BITS         = 2;
  localparam int          WORD_BITS        = 13;  // Shifter: data below MSB, sub-bits, two zeros
  localparam logic [12:0] WORD_RST         = 13'h0000;
  localparam logic [4:0]  CNT_RST          = 5'h00;
  localparam int          BUF_DEPTH        = 2;

  // Power state, one-hot
  typedef enum logic [2:0] {
    PWR_NORMAL  = 3'b001,
    PWR_PARTIAL = 3'b010,
    PWR_FULL    = 3'b100
  } pwr_state_t;

  // Completed result handed to the user side
  typedef struct packed {
    logic [9:0] data;
    logic [1:0] sub_bits;
  } result_t;

  // Serial output pin pair
  typedef struct packed {
    logic o;
    logic oe;
  } pin_out_t;

endpackage : adc_ctl_pkg

// [adc_serial_conversion_control.sv]
// Conversion, power-down and serial readout control of the converter
`timescale 1ns/1ns
module adc_serial_conversion_control #(
  parameter bit BIPOLAR = 1'b0
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 shift_clk,
  input  wire logic                 convert_strobe,
  input  wire logic [9:0]           sample_code,
  input  wire logic [1:0]           sample_sub,
  output logic                      dout_o,
  output logic                      dout_oe,
  output logic                      track_r,
  output logic                      converting_r,
  output logic                      calibrated_r,
  output adc_ctl_pkg::pwr_state_t   pwr_r,
  output adc_ctl_pkg::result_t      res_data,
  output logic                      res_valid,
  input  wire logic                 res_ready,
  output logic                      overrun_r
);
  // Two-flop synchronisers; first stage read only by the second
  logic [1:0] sclk_sync_r;
  logic [1:0] cnv_sync_r;
  logic       sclk_d_r;
  logic       cnv_d_r;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cnv_fall;
  logic       cnv_rise;

  logic [4:0]           edge_cnt_r;
  logic [12:0]          shift_r;
  logic                 fall16_low_r;
  logic                 in_window_r;
  logic                 push_valid_r;
  adc_ctl_pkg::result_t push_data_r;
  logic                 buf_in_ready;
  adc_ctl_pkg::result_t buf_data;
  logic                 buf_valid;
  adc_ctl_pkg::pin_out_t pin_r;
  logic [9:0]           coded;
  logic                 take_ok;

  // Sample asynchronous pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_sync_r <= 2'b00;
      cnv_sync_r  <= 2'b11;
      sclk_d_r    <= 1'b0;
      cnv_d_r     <= 1'b1;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], shift_clk};
      cnv_sync_r  <= {cnv_sync_r[0], convert_strobe};
      sclk_d_r    <= sclk_sync_r[1];
      cnv_d_r     <= cnv_sync_r[1];
    end
  end

  assign sclk_rise = sclk_sync_r[1] && !sclk_d_r;
  assign sclk_fall = !sclk_sync_r[1] && sclk_d_r;
  assign cnv_fall  = !cnv_sync_r[1] && cnv_d_r;
  assign cnv_rise  = cnv_sync_r[1] && !cnv_d_r;

  // Result coding for the selected variant
  function automatic logic [9:0] code_word(input logic [9:0] c);
    code_word = BIPOLAR ? {~c[9], c[8:0]} : c;
  endfunction : code_word

  // One coded word feeds the pin, the shifter and the result path
  assign coded = code_word(sample_code);

  // Rising-edge counter from each strobe fall, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      edge_cnt_r <= adc_ctl_pkg::CNT_RST;
    end else if (cnv_fall) begin
      edge_cnt_r <= adc_ctl_pkg::CNT_RST;
    end else if (sclk_rise && edge_cnt_r != 5'd31) begin
      edge_cnt_r <= edge_cnt_r + 5'd1;
    end
  end

  // Power-down window: edge count 3..13 at the strobe rise
  assign in_window_r = (edge_cnt_r >= 5'(adc_ctl_pkg::PD_WIN_LO)) &&
                       (edge_cnt_r < 5'(adc_ctl_pkg::PD_WIN_HI));

  // Power state machine; steps only on a strobe rise, from any state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_r <= adc_ctl_pkg::PWR_NORMAL;
    end else if (cnv_rise) begin
      unique case (pwr_r)
        adc_ctl_pkg::PWR_NORMAL: begin
          if (in_window_r) pwr_r <= adc_ctl_pkg::PWR_PARTIAL;
        end
        adc_ctl_pkg::PWR_PARTIAL: begin
          if (edge_cnt_r >= 5'(adc_ctl_pkg::WAKE_EDGES)) begin
            pwr_r <= adc_ctl_pkg::PWR_NORMAL;
          end else if (in_window_r) begin
            pwr_r <= adc_ctl_pkg::PWR_FULL;
          end
        end
        adc_ctl_pkg::PWR_FULL: begin
          if (edge_cnt_r >= 5'(adc_ctl_pkg::WAKE_EDGES)) begin
            pwr_r <= adc_ctl_pkg::PWR_NORMAL;
          end
        end
        default: pwr_r <= adc_ctl_pkg::PWR_NORMAL;
      endcase
    end
  end

  // Conversion flag and track/hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      converting_r <= 1'b0;
      track_r      <= 1'b1;  // Tracks straight from power-up
    end else if (cnv_fall) begin
      converting_r <= 1'b1;
      track_r      <= 1'b0;
    end else if (sclk_rise &&
                 edge_cnt_r == 5'(adc_ctl_pkg::TRACK_EDGE - 1)) begin
      track_r <= 1'b1;
    end else if (sclk_rise &&
                 edge_cnt_r == 5'(adc_ctl_pkg::FRAME_EDGES - 1)) begin
      converting_r <= 1'b0;
    end
  end

  // Calibration done after the first full frame; wake needs none
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      calibrated_r <= 1'b0;
    end else if (sclk_rise &&
                 edge_cnt_r == 5'(adc_ctl_pkg::FRAME_EDGES - 1)) begin
      calibrated_r <= 1'b1;
    end
  end

  // Serial shift; loads at MSB edge, shifts on all other rises.
  // The MSB goes to the pin directly, so the shifter starts at bit 8;
  // loading the whole word would send the MSB twice.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_r <= adc_ctl_pkg::WORD_RST;
    end else if (cnv_fall) begin
      shift_r <= adc_ctl_pkg::WORD_RST;
    end else if (sclk_rise) begin
      if (edge_cnt_r == 5'(adc_ctl_pkg::MSB_EDGE - 1)) begin
        shift_r <= {coded[8:0], sample_sub, 2'b00};
      end else begin
        shift_r <= {shift_r[11:0], 1'b0};
      end
    end
  end

  // Strobe still low at 16th falling edge arms the release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fall16_low_r <= 1'b0;
    end else if (cnv_fall) begin
      fall16_low_r <= 1'b0;
    end else if (sclk_fall && !cnv_sync_r[1] &&
                 edge_cnt_r == 5'(adc_ctl_pkg::FRAME_EDGES)) begin
      fall16_low_r <= 1'b1;
    end
  end

  // Output pin drive; all changes tied to clock or strobe edges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_r <= '{o: 1'b0, oe: 1'b0};
    end else if (cnv_fall) begin
      pin_r <= '{o: 1'b0, oe: 1'b1};
    end else if (fall16_low_r && (sclk_rise || cnv_rise)) begin
      pin_r <= '{o: 1'b0, oe: 1'b0};
    end else if (sclk_rise && pin_r.oe) begin
      // Between edges 14 and 16 a strobe rise leaves drive on
      pin_r.o <= (edge_cnt_r == 5'(adc_ctl_pkg::MSB_EDGE - 1)) ?
                 coded[9] : shift_r[12];
    end
  end

  assign dout_o  = pin_r.o;
  assign dout_oe = pin_r.oe;

  // Capture the word at the MSB edge while in normal power
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      push_valid_r <= 1'b0;
      push_data_r  <= '{data: 10'h000, sub_bits: 2'h0};
      overrun_r    <= 1'b0;
    end else if (sclk_rise && pwr_r == adc_ctl_pkg::PWR_NORMAL &&
                 edge_cnt_r == 5'(adc_ctl_pkg::MSB_EDGE - 1)) begin
      push_valid_r <= 1'b1;
      push_data_r  <= '{data: coded, sub_bits: sample_sub};
      overrun_r    <= push_valid_r && !buf_in_ready;
    end else if (buf_in_ready) begin
      push_valid_r <= 1'b0;  // Held while full; a new capture overwrites it and sets overrun_r
    end
  end

  result_buf u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (push_data_r),
    .in_valid  (push_valid_r),
    .in_ready  (buf_in_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (take_ok)
  );

  // Output stage refills only when empty or being taken, so the
  // buffer never pops a word that the user has not yet seen
  assign take_ok = !res_valid || res_ready;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_data  <= '{data: 10'h000, sub_bits: 2'h0};
    end else if (take_ok) begin
      res_valid <= buf_valid;
      if (buf_valid) res_data <= buf_data;
    end
  end

  // Assertions
  property p_start_drive;
    @(posedge clk) disable iff (!rst_n)
      cnv_fall |=> (dout_oe && !dout_o && !track_r);
  endproperty
  a_start_drive: assert property (p_start_drive)
    else $error("output not driven low at start");

  property p_enter_partial;
    @(posedge clk) disable iff (!rst_n)
      (cnv_rise && pwr_r == adc_ctl_pkg::PWR_NORMAL && in_window_r)
      |=> pwr_r == adc_ctl_pkg::PWR_PARTIAL;
  endproperty
  a_enter_partial: assert property (p_enter_partial)
    else $error("partial power-down not entered");

  property p_enter_full;
    @(posedge clk) disable iff (!rst_n)
      $changed(pwr_r) && pwr_r == adc_ctl_pkg::PWR_FULL
      |-> $past(pwr_r) == adc_ctl_pkg::PWR_PARTIAL;
  endproperty
  a_enter_full: assert property (p_enter_full)
    else $error("full power-down entered from wrong state");

  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      (cnv_rise && pwr_r != adc_ctl_pkg::PWR_NORMAL && edge_cnt_r >= 5'd14)
      |=> pwr_r == adc_ctl_pkg::PWR_NORMAL;
  endproperty
  a_wake: assert property (p_wake)
    else $error("power-down not left after wake sequence");

  property p_release;
    @(posedge clk) disable iff (!rst_n)
      (fall16_low_r && sclk_rise && !cnv_fall) |=> !dout_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("output not released after frame");

  property p_change_on_rise;
    @(posedge clk) disable iff (!rst_n)
      $changed(dout_o) |-> $past(sclk_rise) || $past(cnv_fall) ||
                           $past(fall16_low_r);
  endproperty
  a_change_on_rise: assert property (p_change_on_rise)
    else $error("output changed off a rising edge");

  property p_track_14;
    @(posedge clk) disable iff (!rst_n)
      (sclk_rise && edge_cnt_r == 5'd13 && !cnv_fall) |=> track_r;
  endproperty
  a_track_14: assert property (p_track_14)
    else $error("track not resumed at edge 14");

  property p_msb;
    @(posedge clk) disable iff (!rst_n)
      (sclk_rise && edge_cnt_r == 5'd3 && dout_oe && !cnv_fall)
      |=> dout_o == (sample_code[9] ^ BIPOLAR) && shift_r[12] ==
          $past(sample_code[8]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("msb not presented on fourth edge");

  property p_keep_drive;
    @(posedge clk) disable iff (!rst_n)
      (cnv_rise && edge_cnt_r >= 5'd14 && edge_cnt_r < 5'd16 && dout_oe)
      |=> dout_oe;
  endproperty
  a_keep_drive: assert property (p_keep_drive)
    else $error("output dropped in continuous window");

  c_partial: cover property (@(posedge clk) disable iff (!rst_n)
    pwr_r == adc_ctl_pkg::PWR_PARTIAL);
  c_full: cover property (@(posedge clk) disable iff (!rst_n)
    pwr_r == adc_ctl_pkg::PWR_FULL);
  c_release: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(dout_oe));
  c_result: cover property (@(posedge clk) disable iff (!rst_n)
    res_valid && res_ready);
endmodule : adc_serial_conversion_control

// [adc_serial_conversion_control_tb_top.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module adc_serial_conversion_control_tb_top;
  logic                    clk = 1'b0;
  logic                    rst_n;
  logic                    shift_clk;
  logic                    convert_strobe;
  logic [9:0]              sample_code;
  logic [1:0]              sample_sub;
  logic                    res_ready;
  logic                    dout_o;
  logic                    dout_oe;
  logic                    dout_last_r = 1'b0;
  logic                    dout_line;
  logic                    track_r;
  logic                    converting_r;
  logic                    calibrated_r;
  adc_ctl_pkg::pwr_state_t pwr_r;
  adc_ctl_pkg::result_t    res_data;
  adc_ctl_pkg::result_t    res_data_b;
  logic                    res_valid;
  logic                    overrun_r;
  logic [16:0]             w;
  int                      failures;
  int                      cmp_count;

  // 250 MHz system clock
  always #2 clk = ~clk;

  // Released line shows the inverse so a stale bit cannot pass
  always @(posedge clk) if (dout_oe) dout_last_r <= dout_o;
  assign dout_line = dout_oe ? dout_o : ~dout_last_r;

  adc_serial_conversion_control #(.BIPOLAR(1'b0)) dut_u (
    .clk(clk), .rst_n(rst_n), .shift_clk(shift_clk),
    .convert_strobe(convert_strobe), .sample_code(sample_code),
    .sample_sub(sample_sub), .dout_o(dout_o), .dout_oe(dout_oe),
    .track_r(track_r), .converting_r(converting_r),
    .calibrated_r(calibrated_r), .pwr_r(pwr_r), .res_data(res_data),
    .res_valid(res_valid), .res_ready(res_ready), .overrun_r(overrun_r)
  );

  // Bipolar twin sees the same pins; only its results are compared
  adc_serial_conversion_control #(.BIPOLAR(1'b1)) dut_b (
    .clk(clk), .rst_n(rst_n), .shift_clk(shift_clk),
    .convert_strobe(convert_strobe), .sample_code(sample_code),
    .sample_sub(sample_sub), .dout_o(), .dout_oe(), .track_r(),
    .converting_r(), .calibrated_r(), .pwr_r(), .res_data(res_data_b),
    .res_valid(), .res_ready(res_ready), .overrun_r()
  );

  host_master host_u (
    .clk(clk), .dout_line(dout_line), .shift_clk(shift_clk),
    .convert_strobe(convert_strobe)
  );

  // Verdict and end of run
  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Expected frame: leading low, three zeros, code, sub-bits, zero
  function automatic logic [16:0] ew(input logic [9:0] c,
                                     input logic [1:0] s);
    return {4'h0, c, s, 1'b0};
  endfunction : ew

  // One full frame read and judged
  task automatic rd(input logic [9:0] c, input logic [1:0] s,
                    input int r, input bit fs);
    sample_code = c;
    sample_sub  = s;
    host_u.frame(16, r, fs, w);
    check("frame", 32'(w), 32'(ew(c, s)));
  endtask : rd

  // Reset state, calibration, release on strobe rise, both capture modes
  task automatic t_single();
    check("oe", 32'(dout_oe), 32'h0);
    check("track", 32'(track_r), 32'h1);
    check("cal", 32'(calibrated_r), 32'h0);
    check("pwr", 32'(pwr_r), 32'(adc_ctl_pkg::PWR_NORMAL));
    rd(10'h2a5, 2'h2, 0, 1'b0);
    check("cal", 32'(calibrated_r), 32'h1);
    check("conv", 32'(converting_r), 32'h0);
    check("oe", 32'(dout_oe), 32'h1);
    host_u.strobe_hi();
    check("oe", 32'(dout_oe), 32'h0);
    rd(10'h1ff, 2'h1, 0, 1'b1);
    host_u.strobe_hi();
  endtask : t_single

  // Back-to-back frames with the strobe raised in rise 15 of 16
  task automatic t_cont();
    rd(10'h300, 2'h3, 15, 1'b0);
    check("oe", 32'(dout_oe), 32'h1);
    check("pwr", 32'(pwr_r), 32'(adc_ctl_pkg::PWR_NORMAL));
    rd(10'h0c1, 2'h0, 0, 1'b0);
    host_u.strobe_hi();
  endtask : t_cont

  // Track returns at rise 14; a 17th rise releases the output
  task automatic t_track();
    host_u.frame(13, 0, 1'b0, w);
    check("track", 32'(track_r), 32'h0);
    check("conv", 32'(converting_r), 32'h1);
    host_u.tick();
    check("track", 32'(track_r), 32'h1);
    host_u.tick();
    host_u.tick();
    check("oe", 32'(dout_oe), 32'h1);
    host_u.tick();
    check("oe", 32'(dout_oe), 32'h0);
    host_u.strobe_hi();
  endtask : t_track

  // Short frame with strobe rise at r, then judge the power state
  task automatic pd(input int n, input int r, input logic [2:0] exp);
    host_u.frame(n, r, 1'b0, w);
    host_u.strobe_hi();
    check("pwr", 32'(pwr_r), 32'(exp));
  endtask : pd

  // Window edges 2, 3 and 13, then wake-ups and the 8-bit entry
  task automatic t_pd();
    pd(2, 2, adc_ctl_pkg::PWR_NORMAL);
    pd(3, 3, adc_ctl_pkg::PWR_PARTIAL);
    pd(13, 13, adc_ctl_pkg::PWR_FULL);
    pd(14, 0, adc_ctl_pkg::PWR_NORMAL);
    pd(8, 8, adc_ctl_pkg::PWR_PARTIAL);
    pd(14, 0, adc_ctl_pkg::PWR_NORMAL);
  endtask : t_pd

  // Take the head word, bounded wait for valid
  task automatic pop(input logic [9:0] c, input logic [1:0] s);
    int i;
    i = 0;
    while (res_valid !== 1'b1 && i < 50) begin
      host_u.hw(1);
      i++;
    end
    if (i == 50) begin
      failures++;
      wrap_up();
    end
    check("res", 32'(res_data), 32'({c, s}));
    check("res_b", 32'(res_data_b), 32'({~c[9], c[8:0], s}));
    res_ready = 1'b1;
    host_u.hw(1);
    res_ready = 1'b0;
    host_u.hw(2);
  endtask : pop

  // Stalled sink: output, two buffer slots and the capture stage hold
  // four words; the fifth overwrites the fourth; drain in order
  task automatic t_buf();
    res_ready = 1'b0;
    rd(10'h155, 2'h1, 0, 1'b0);
    host_u.strobe_hi();
    rd(10'h2aa, 2'h2, 0, 1'b0);
    host_u.strobe_hi();
    rd(10'h3c3, 2'h3, 0, 1'b0);
    host_u.strobe_hi();
    rd(10'h0f0, 2'h0, 0, 1'b0);
    host_u.strobe_hi();
    check("valid", 32'(res_valid), 32'h1);
    check("ovr", 32'(overrun_r), 32'h0);
    rd(10'h30c, 2'h1, 0, 1'b0);
    host_u.strobe_hi();
    check("ovr", 32'(overrun_r), 32'h1);
    pop(10'h155, 2'h1);
    pop(10'h2aa, 2'h2);
    pop(10'h3c3, 2'h3);
    pop(10'h30c, 2'h1);
    check("valid", 32'(res_valid), 32'h0);
    res_ready = 1'b1;
  endtask : t_buf

  // Main sequence
  initial begin
    failures    = 0;
    cmp_count   = 0;
    rst_n       = 1'b0;
    sample_code = 10'h000;
    sample_sub  = 2'h0;
    res_ready   = 1'b1;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_single();
    t_cont();
    t_track();
    t_pd();
    t_buf();
    wrap_up();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule : adc_serial_conversion_control_tb_top

// [host_master.sv]
// Host serial master model: drives strobe and shift clock, reads data
`timescale 1ns/1ns
module host_master (
  input  wire logic clk,
  input  wire logic dout_line,
  output logic      shift_clk,
  output logic      convert_strobe
);
  // Strobe idles high and the clock stays parked between frames
  initial begin
    shift_clk      = 1'b0;
    convert_strobe = 1'b1;
  end

  // Eight system cycles make a 32 ns half period, well under the limit
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask : hw

  // One shift-clock pulse, strobe untouched
  task automatic tick();
    shift_clk = 1'b1;
    hw(8);
    shift_clk = 1'b0;
    hw(8);
  endtask : tick

  // Frame of n rises; strobe rises inside rise r (0 keeps it low);
  // fs captures on falling edges, else just before the next rise
  task automatic frame(input int n, input int r, input bit fs,
                       output logic [16:0] w);
    w = 17'h00000;
    convert_strobe = 1'b0;
    hw(8);
    w = {w[15:0], dout_line};
    for (int k = 1; k <= n; k++) begin
      shift_clk = 1'b1;
      hw(4);
      if (k == r) convert_strobe = 1'b1;
      hw(4);
      if (fs) w = {w[15:0], dout_line};
      shift_clk = 1'b0;
      hw(8);
      if (!fs) w = {w[15:0], dout_line};
    end
  endtask : frame

  // Return the strobe to its idle level
  task automatic strobe_hi();
    convert_strobe = 1'b1;
    hw(8);
  endtask : strobe_hi
endmodule : host_master

// [result_buf.sv]
// Two-entry valid/ready buffer for completed results
`timescale 1ns/1ns
module result_buf (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire adc_ctl_pkg::result_t in_data,
  input  wire logic                in_valid,
  output logic                     in_ready,
  output adc_ctl_pkg::result_t     out_data,
  output logic                     out_valid,
  input  wire logic                out_ready
);
  adc_ctl_pkg::result_t mem_r [adc_ctl_pkg::BUF_DEPTH];
  logic                 wp_r;
  logic                 rp_r;
  logic [1:0]           cnt_r;
  logic                 push;
  logic                 pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : result_buf
